// file: common/lgc_consts.vh
`ifndef LGC_CONSTS_VH
`define LGC_CONSTS_VH

// Control word layout
`define LGC_WORD_W        9
`define LGC_FINE_LSB      0
`define LGC_FINE_MSB      3
`define LGC_COARSE_LSB    4
`define LGC_COARSE_MSB    7
`define LGC_ATTEN_BIT     8

// APB register byte offsets
`define LGC_ADDR_W        4
`define LGC_OFS_CTRL      4'h0
`define LGC_OFS_WORD      4'h4
`define LGC_OFS_STATUS    4'h8
`define LGC_OFS_RDBACK    4'hC

// Control register fields
`define LGC_CTRL_GO       0
`define LGC_CTRL_READ     1
`define LGC_CTRL_SER      2
`define LGC_CTRL_PWRDN    3

// Status register fields
`define LGC_STAT_BUSY     0
`define LGC_STAT_DONE     1

// Serial link timing, in ns (minimums)
`define LGC_CLK_NS        20
`define LGC_SCK_HALF_NS   250
`define LGC_STROBE_NS     50
`define LGC_SETUP_NS      50

`endif

// file: src/lgc_tick.v
`timescale 1ns/1ns
`include "lgc_consts.vh"

// ----------------------------------------
// Phase timer for the serial link
// ----------------------------------------
module lgc_tick #(
  parameter CNT_W = 8
) (
  input  wire             clk,
  input  wire             srst,
  input  wire             start,
  input  wire [CNT_W-1:0] len,
  output wire             done
);

  reg [CNT_W-1:0] cnt_reg;

  // Loads on start, counts down to zero; done while zero and start is low
  always @(posedge clk)
  begin
    if (srst)
      cnt_reg <= {CNT_W{1'b0}};
    else if (start)
      cnt_reg <= len;
    else if (cnt_reg != {CNT_W{1'b0}})
      cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
  end

  assign done = (cnt_reg == {CNT_W{1'b0}}) & ~start;

endmodule

// file: src/lgc_host.v
`timescale 1ns/1ns
`include "lgc_consts.vh"

// How it works
// - Load latch strobe pulsed only while shift clock is low.
// - First bit shifted becomes word bit 0.
// - Readback strobe pulsed only while shift clock is low.
// - Link is static; host timing only respects minimum widths.
// - Writes and reads may follow back to back; a GO or word write while busy is ignored.
module lgc_host #(
  parameter WORD_W = `LGC_WORD_W,
  parameter CNT_W  = 8
) (
  input  wire        REF_CLK,
  input  wire        SRST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  output reg         INTERFACE_SELECT,
  output reg         POWER_DOWN_INPUT,
  output reg         SHIFT_CLOCK,
  output reg         SERIAL_DATA_IN,
  output reg         LOAD_LATCH_STROBE,
  output reg         READBACK_STROBE,
  input  wire        SERIAL_DATA_OUT,
  output reg         ATTENUATE_SELECT,
  output reg  [3:0]  COARSE_SELECT,
  output reg  [3:0]  FINE_SELECT
);

  // ----------------------------------------
  // Timing counts derived from 50 MHz
  // ----------------------------------------
  localparam [CNT_W-1:0] HALF_CYC =
    (`LGC_SCK_HALF_NS + `LGC_CLK_NS - 1) / `LGC_CLK_NS;
  localparam [CNT_W-1:0] STRB_CYC =
    (`LGC_STROBE_NS + `LGC_CLK_NS - 1) / `LGC_CLK_NS;
  localparam [CNT_W-1:0] SETUP_CYC =
    (`LGC_SETUP_NS + `LGC_CLK_NS - 1) / `LGC_CLK_NS;

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_LOW   = 3'h1;
  localparam [2:0] S_HIGH  = 3'h2;
  localparam [2:0] S_PRE   = 3'h3;
  localparam [2:0] S_STRB  = 3'h4;
  localparam [2:0] S_POST  = 3'h5;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [WORD_W-1:0] word_reg;
  reg [WORD_W-1:0] rdback_reg;
  reg [WORD_W-1:0] sh_reg;
  reg [2:0]        state_reg;
  reg [3:0]        bit_reg;
  reg              rd_reg;
  reg              done_reg;
  reg              dout_meta_reg;
  reg              dout_sync_reg;
  reg              t_start;
  reg [CNT_W-1:0]  t_len;
  wire             t_done;

  wire wr_en = PSEL & PENABLE & PWRITE;
  wire rd_en = PSEL & PENABLE & ~PWRITE;
  wire [`LGC_ADDR_W-1:0] ofs = PADDR[`LGC_ADDR_W-1:0];
  wire busy = (state_reg != S_IDLE);
  wire go = wr_en & (ofs == `LGC_OFS_CTRL) & PWDATA[`LGC_CTRL_GO] & ~busy;

  // Register map decode, used for reads and the error answer
  function mapped;
    input [`LGC_ADDR_W-1:0] a;
    begin
      mapped = (a == `LGC_OFS_CTRL) | (a == `LGC_OFS_WORD) |
               (a == `LGC_OFS_STATUS) | (a == `LGC_OFS_RDBACK);
    end
  endfunction

  wire addr_ok = mapped(ofs) & (PADDR[31:`LGC_ADDR_W] == 28'h0000000); // Upper bits must be clear too
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;

  lgc_tick #(.CNT_W(CNT_W)) u_tick (
    .clk   (REF_CLK),
    .srst  (SRST),
    .start (t_start),
    .len   (t_len),
    .done  (t_done)
  );

  // Serial data out is asynchronous to us: two-flop synchroniser
  always @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      dout_meta_reg <= 1'b0;
      dout_sync_reg <= 1'b0;
    end
    else
    begin
      dout_meta_reg <= SERIAL_DATA_OUT;
      dout_sync_reg <= dout_meta_reg;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      word_reg         <= {WORD_W{1'b0}};
      INTERFACE_SELECT <= 1'b1;
      POWER_DOWN_INPUT <= 1'b0;
    end
    else if (wr_en & (ofs == `LGC_OFS_WORD) & ~busy)
      word_reg <= PWDATA[WORD_W-1:0];
    else if (wr_en & (ofs == `LGC_OFS_CTRL))
    begin
      INTERFACE_SELECT <= PWDATA[`LGC_CTRL_SER];
      POWER_DOWN_INPUT <= PWDATA[`LGC_CTRL_PWRDN];
    end
  end

  // Parallel pins follow the word; zero in serial mode so they stay quiet
  always @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      ATTENUATE_SELECT <= 1'b0;
      COARSE_SELECT    <= 4'h0;
      FINE_SELECT      <= 4'h0;
    end
    else
    begin
      ATTENUATE_SELECT <= ~INTERFACE_SELECT & word_reg[`LGC_ATTEN_BIT];
      COARSE_SELECT    <= INTERFACE_SELECT ? 4'h0 : word_reg[`LGC_COARSE_MSB:`LGC_COARSE_LSB];
      FINE_SELECT      <= INTERFACE_SELECT ? 4'h0 : word_reg[`LGC_FINE_MSB:`LGC_FINE_LSB];
    end
  end

  // APB read data, registered on the setup cycle
  always @(posedge REF_CLK)
  begin
    if (SRST)
      PRDATA <= 32'h00000000;
    else if (PSEL & ~PENABLE & ~PWRITE & ~addr_ok)
      PRDATA <= 32'h00000000;  // Erroneous reads answer zero
    else if (PSEL & ~PENABLE & ~PWRITE)
    begin
      case (ofs)
        `LGC_OFS_CTRL:   PRDATA <= {28'h0000000, POWER_DOWN_INPUT, INTERFACE_SELECT, rd_reg, 1'b0};
        `LGC_OFS_WORD:   PRDATA <= {{(32-WORD_W){1'b0}}, word_reg};
        `LGC_OFS_STATUS: PRDATA <= {30'h00000000, done_reg, busy};
        `LGC_OFS_RDBACK: PRDATA <= {{(32-WORD_W){1'b0}}, rdback_reg};
        default:         PRDATA <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Serial sequencer
  // ----------------------------------------
  // Write: shift nine bits, then pulse load strobe with clock low.
  // Read: pulse readback strobe with clock low, then sample nine bits.
  always @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      state_reg         <= S_IDLE;
      bit_reg           <= 4'h0;
      rd_reg            <= 1'b0;
      done_reg          <= 1'b0;
      sh_reg            <= {WORD_W{1'b0}};
      rdback_reg        <= {WORD_W{1'b0}};
      SHIFT_CLOCK       <= 1'b0;
      SERIAL_DATA_IN    <= 1'b0;
      LOAD_LATCH_STROBE <= 1'b0;
      READBACK_STROBE   <= 1'b0;
      t_start           <= 1'b0;
      t_len             <= {CNT_W{1'b0}};
    end
    else
    begin
      t_start <= 1'b0;
      if (rd_en & (ofs == `LGC_OFS_STATUS) & PRDATA[`LGC_STAT_DONE]) // Clear only what software saw
        done_reg <= 1'b0;
      case (state_reg)
        S_IDLE:
          if (go)
          begin
            rd_reg   <= PWDATA[`LGC_CTRL_READ];
            done_reg <= 1'b0;
            bit_reg  <= 4'h0;
            t_start  <= 1'b1;
            if (PWDATA[`LGC_CTRL_READ])
            begin
              t_len     <= SETUP_CYC;
              state_reg <= S_PRE;
            end
            else
            begin
              sh_reg         <= word_reg;
              SERIAL_DATA_IN <= word_reg[0];
              t_len          <= HALF_CYC;
              state_reg      <= S_LOW;
            end
          end
        S_LOW:
          if (t_done & ~t_start)
          begin
            SHIFT_CLOCK <= 1'b1;
            if (rd_reg)
              rdback_reg <= {dout_sync_reg, rdback_reg[WORD_W-1:1]};
            t_start   <= 1'b1;
            t_len     <= HALF_CYC;
            state_reg <= S_HIGH;
          end
        S_HIGH:
          if (t_done & ~t_start)
          begin
            SHIFT_CLOCK <= 1'b0;
            bit_reg     <= bit_reg + 4'h1;
            t_start     <= 1'b1;
            if (bit_reg == WORD_W - 1)
            begin
              t_len     <= SETUP_CYC;
              state_reg <= rd_reg ? S_POST : S_PRE;
            end
            else
            begin
              sh_reg         <= {1'b0, sh_reg[WORD_W-1:1]};
              SERIAL_DATA_IN <= sh_reg[1];
              t_len          <= HALF_CYC;
              state_reg      <= S_LOW;
            end
          end
        S_PRE:
          if (t_done & ~t_start)
          begin
            if (rd_reg)
              READBACK_STROBE <= 1'b1;
            else
              LOAD_LATCH_STROBE <= 1'b1;
            t_start   <= 1'b1;
            t_len     <= STRB_CYC;
            state_reg <= S_STRB;
          end
        S_STRB:
          if (t_done & ~t_start)
          begin
            LOAD_LATCH_STROBE <= 1'b0;
            READBACK_STROBE   <= 1'b0;
            t_start           <= 1'b1;
            t_len             <= HALF_CYC;   // settle, then clock out on reads, finish on writes
            state_reg         <= rd_reg ? S_LOW : S_POST;
          end
        S_POST:
          if (t_done & ~t_start)
          begin
            done_reg  <= 1'b1;               // next request may follow
            state_reg <= S_IDLE;
          end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // latch kept through power-down; pins always driven here

endmodule

// file: testbench/lgc_host_sva.sv
`timescale 1ns/1ns
// ----------------------------------------
// Link timing checks
// ----------------------------------------
module lgc_host_sva (
  input wire       REF_CLK,
  input wire       SRST,
  input wire       INTERFACE_SELECT,
  input wire       SHIFT_CLOCK,
  input wire       SERIAL_DATA_IN,
  input wire       LOAD_LATCH_STROBE,
  input wire       READBACK_STROBE,
  input wire       ATTENUATE_SELECT,
  input wire [3:0] COARSE_SELECT,
  input wire [3:0] FINE_SELECT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // Strobes only while the clock rests low
  load_clk_low_a: assert property (LOAD_LATCH_STROBE |-> !SHIFT_CLOCK)
    else $error("load strobe with clock high");
  rdbk_clk_low_a: assert property (READBACK_STROBE |-> !SHIFT_CLOCK)
    else $error("readback strobe with clock high");
  // Pulse is five samples wide: timer load cycle plus three counts plus the zero cycle
  load_width_a: assert property ($rose(LOAD_LATCH_STROBE) |-> LOAD_LATCH_STROBE[*5] ##1 !LOAD_LATCH_STROBE)
    else $error("load strobe width");
  rdbk_width_a: assert property ($rose(READBACK_STROBE) |-> READBACK_STROBE[*5] ##1 !READBACK_STROBE)
    else $error("readback strobe width");
  load_setup_a: assert property ($rose(LOAD_LATCH_STROBE) |-> !$past(SHIFT_CLOCK, 3))
    else $error("load strobe setup");
  load_hold_a: assert property ($fell(LOAD_LATCH_STROBE) |-> !SHIFT_CLOCK [*3])
    else $error("load strobe hold");
  // High phase lasts 15 samples, comfortably above 250 ns
  sck_high_a: assert property ($rose(SHIFT_CLOCK) |-> ##15 $fell(SHIFT_CLOCK))
    else $error("clock high time");
  sdi_stable_a: assert property (SHIFT_CLOCK |-> $stable(SERIAL_DATA_IN))
    else $error("data moved while clock high");
  ser_pins_a: assert property (INTERFACE_SELECT && $past(INTERFACE_SELECT)
    |-> {ATTENUATE_SELECT, COARSE_SELECT, FINE_SELECT} == 9'h000)
    else $error("select pins driven in serial mode");
  c_load_c: cover property ($rose(LOAD_LATCH_STROBE));
  c_read_c: cover property ($rose(READBACK_STROBE));
  c_par_c: cover property (!INTERFACE_SELECT);
endmodule
bind lgc_host lgc_host_sva chk (.*);

// file: testbench/lgc_dev_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Gain device model
// ----------------------------------------
module lgc_dev_model (
  input  wire       ser,
  input  wire       pwr_dn,
  input  wire       sck,
  input  wire       sdi,
  input  wire       load_stb,
  input  wire       rdbk_stb,
  input  wire       att,
  input  wire [3:0] crs,
  input  wire [3:0] fin,
  output reg        ser_out,
  output reg  [8:0] lat_reg,
  output wire [8:0] gain,
  output wire       vout_off
);
  reg  [8:0] sr_reg;
  reg        out_reg;
  reg  [8:0] pins;
  wire [8:0] raw = {att, crs, fin};
  integer    db10;
  integer    k;
  // Shift on rising clock; readback reload wins
  always @(posedge sck or posedge rdbk_stb)
    if (ser && rdbk_stb)
      sr_reg <= lat_reg;
    else if (ser)
      sr_reg <= {sdi, sr_reg[8:1]};
  // Transparent latch; shifting leaves it alone
  always @*
    if (ser && load_stb)
      lat_reg = sr_reg;
  // Output moves on falling clock
  always @(negedge sck or posedge rdbk_stb)
    out_reg <= rdbk_stb ? lat_reg[0] : sr_reg[0];
  // Slow output: wrong level until 120 ns pass
  always @(out_reg)
  begin
    ser_out = ~out_reg;
    #120 ser_out = out_reg;
  end
  // Pull-downs: a floating select pin reads low, an unknown stays unknown
  always @*
    for (k = 0; k < 9; k = k + 1)
      pins[k] = (raw[k] === 1'bz) ? 1'b0 : raw[k];
  assign gain = ser ? lat_reg : pins;
  assign vout_off = pwr_dn;
  // Gain in tenths of a dB
  always @*
    db10 = (gain[8] ? -1 : 1) * (gain[7:4] * 15 + gain[3:0]);
endmodule

// file: testbench/lgc_host_tb_top.sv
`timescale 1ns/1ns
`include "lgc_consts.vh"
// ----------------------------------------
// Host controller bench
// ----------------------------------------
module lgc_host_tb_top;
  reg         clk, srst, psel, penable, pwrite, err;
  reg  [31:0] paddr, pwdata, rd;
  reg  [8:0]  w;
  reg  [8:0]  q[$];
  wire [31:0] prdata;
  wire        pready, pslverr, ser, pwr_dn, sck, sdi, load_stb, rdbk_stb, ser_out, att;
  wire [3:0]  crs, fin;
  wire [8:0]  lat, gain;
  integer     errors, num_checks, seed, i;

  lgc_host dut (.REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INTERFACE_SELECT(ser), .POWER_DOWN_INPUT(pwr_dn), .SHIFT_CLOCK(sck), .SERIAL_DATA_IN(sdi),
    .LOAD_LATCH_STROBE(load_stb), .READBACK_STROBE(rdbk_stb), .SERIAL_DATA_OUT(ser_out),
    .ATTENUATE_SELECT(att), .COARSE_SELECT(crs), .FINE_SELECT(fin));
  lgc_dev_model model (.ser(ser), .pwr_dn(pwr_dn), .sck(sck), .sdi(sdi), .load_stb(load_stb),
    .rdbk_stb(rdbk_stb), .att(att), .crs(crs), .fin(fin), .ser_out(ser_out), .lat_reg(lat), .gain(gain),
    .vout_off());

  // Free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task end_sim;
  begin
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  task chk(input string name, input [31:0] exp, input [31:0] got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("ERROR %0s exp %h got %h", name, exp, got);
    end
  end
  endtask

  // One APB transfer; idle cycle after so strobes never toggle twice
  task apb(input [31:0] a, input wr, input [31:0] d);
    integer n;
  begin
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n = n + 1;
      @(posedge clk);
    end
    if (n == 50)
    begin
      errors = errors + 1;
      end_sim;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  end
  endtask

  // Poll status until done, bounded
  task wait_done;
    integer n;
  begin
    rd = 0;
    for (n = 0; n < 1000 && rd[1] !== 1'b1; n = n + 1)
      apb(`LGC_OFS_STATUS, 1'b0, 0);
    if (rd[1] !== 1'b1)
    begin
      errors = errors + 1;
      end_sim;
    end
  end
  endtask

  initial
  begin
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    errors = 0;
    num_checks = 0;
    seed = 32'h6d56;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    chk("ser", 1, ser);
    chk("pwr_dn", 0, pwr_dn);
    // Write, refused rewrite, readback; odd passes in power-down
    for (i = 0; i < 6; i = i + 1)
    begin
      w = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : 9'($random(seed));
      q.push_back(w);
      apb(`LGC_OFS_WORD, 1'b1, w);
      apb(`LGC_OFS_CTRL, 1'b1, 32'h5 | ((i % 2) << 3));
      apb(`LGC_OFS_WORD, 1'b1, ~w);
      if (i > 0)
        chk("held", q[0], lat);
      wait_done;
      chk("latch", q[$], lat);
      chk("gain", q[$], gain);
      chk("db10", (w[8] ? -1 : 1) * (w[7:4] * 15 + w[3:0]), model.db10);
      chk("pwr_dn", i % 2, pwr_dn);
      apb(`LGC_OFS_WORD, 1'b0, 0);
      chk("word", q[$], rd);
      apb(`LGC_OFS_STATUS, 1'b0, 0);
      chk("status", 0, rd);
      apb(`LGC_OFS_CTRL, 1'b1, 32'h7 | ((i % 2) << 3));
      wait_done;
      apb(`LGC_OFS_RDBACK, 1'b0, 0);
      chk("rdback", q[$], rd);
      chk("slverr", 0, err);
      if (q.size() > 1)
        w = q.pop_front();
    end
    // Parallel mode drives pins straight from the word
    apb(`LGC_OFS_CTRL, 1'b1, 0);
    w = 9'($random(seed));
    apb(`LGC_OFS_WORD, 1'b1, w);
    @(posedge clk);
    chk("ser", 0, ser);
    chk("par", w, gain);
    apb(32'h10, 1'b0, 0);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
    end_sim;
  end
endmodule
